// *** rtl/pct_pkg.sv ***
// constants shared by the 16-bit waveform and capture timer
package pct_pkg;
	// register word addresses
	localparam logic [3:0] ADDR_CTRL_A = 4'h0;
	localparam logic [3:0] ADDR_CTRL_B = 4'h1;
	localparam logic [3:0] ADDR_COUNT = 4'h2;
	localparam logic [3:0] ADDR_CMP_A = 4'h3;
	localparam logic [3:0] ADDR_CMP_B = 4'h4;
	localparam logic [3:0] ADDR_CAPT = 4'h5;
	localparam logic [3:0] ADDR_STATUS = 4'h6;
	localparam logic [3:0] ADDR_MASK = 4'h7;
	// counter_control_b fields
	localparam int CB_FILTER_BIT = 7;
	localparam int CB_EDGE_BIT = 6;
	localparam int CB_WGM_LSB = 3;
	localparam int CB_CS_LSB = 0;
	localparam logic [7:0] CTRL_B_WMASK = 8'hDF;
	// counter_control_a fields
	localparam int CA_COMA_LSB = 6;
	localparam int CA_COMB_LSB = 4;
	localparam int CA_WGM_LSB = 0;
	localparam logic [7:0] CTRL_A_WMASK = 8'hF3;
	// status and mask bits
	localparam int STAT_W = 4;
	localparam int ST_CMP_A = 0;
	localparam int ST_CMP_B = 1;
	localparam int ST_CAPT = 2;
	localparam int ST_OVF = 3;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [STAT_W-1:0] STAT_RST = 4'h0;
	// fixed tops
	localparam logic [15:0] TOP_8BIT = 16'h00FF;
	localparam logic [15:0] TOP_9BIT = 16'h01FF;
	localparam logic [15:0] TOP_10BIT = 16'h03FF;
	localparam logic [15:0] TOP_MAX = 16'hFFFF;
	// clock source select codes and prescaler taps
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	localparam int PRESCALE_W = 10;
	localparam int LOG2_DIV8 = 3;
	localparam int LOG2_DIV64 = 6;
	localparam int LOG2_DIV256 = 8;
	localparam int LOG2_DIV1024 = 10;
	// capture noise filter length in samples
	localparam int FILTER_SAMPLES = 4;
	// waveform modes
	localparam logic [3:0] WM_NORMAL = 4'h0;
	localparam logic [3:0] WM_PC8 = 4'h1;
	localparam logic [3:0] WM_PC9 = 4'h2;
	localparam logic [3:0] WM_PC10 = 4'h3;
	localparam logic [3:0] WM_CTC_A = 4'h4;
	localparam logic [3:0] WM_FAST8 = 4'h5;
	localparam logic [3:0] WM_FAST9 = 4'h6;
	localparam logic [3:0] WM_FAST10 = 4'h7;
	localparam logic [3:0] WM_PFC_ICR = 4'h8;
	localparam logic [3:0] WM_PFC_A = 4'h9;
	localparam logic [3:0] WM_PC_ICR = 4'hA;
	localparam logic [3:0] WM_PC_A = 4'hB;
	localparam logic [3:0] WM_CTC_ICR = 4'hC;
	localparam logic [3:0] WM_FAST_ICR = 4'hE;
	localparam logic [3:0] WM_FAST_A = 4'hF;
	// compare output modes
	localparam logic [1:0] COM_OFF = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR = 2'h2;
	localparam logic [1:0] COM_SET = 2'h3;
endpackage : pct_pkg

// *** rtl/pct_cap_if.sv ***
// control and event signals between the timer core and its capture front end
`timescale 1ns/1ps
interface pct_cap_if;
	logic filter_en;
	logic edge_sel;
	logic enable;
	logic event_pulse;
	modport unit (input filter_en, input edge_sel, input enable, output event_pulse);
	modport core (output filter_en, output edge_sel, output enable, input event_pulse);
endinterface : pct_cap_if

// *** rtl/pct_prescaler.sv ***
// timer clock enable: prescaler taps and external count pin edge detect
`timescale 1ns/1ps
module pct_prescaler (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// selection
	input wire logic [2:0] clock_source_sel,
	// external count pin, asynchronous
	input wire logic ext_count_pin,
	// one-cycle timer clock enable
	output logic timer_tick
);
	typedef struct packed {
		logic [pct_pkg::PRESCALE_W-1:0] pre;
		logic s1;
		logic s2;
		logic s3;
		logic tick;
	} pct_pre_state_t;

	pct_pre_state_t r_reg, r_next;

	// true when the low exp bits of the prescaler are all ones
	function automatic logic tap_hit(input logic [pct_pkg::PRESCALE_W-1:0] pre, input int exp);
		logic [pct_pkg::PRESCALE_W-1:0] m;
		m = pct_pkg::PRESCALE_W'((1 << exp) - 1);
		return (pre & m) == m;
	endfunction : tap_hit

	////////////////////////////////////////////////////////////////
	// divider runs whenever the clock is not stopped, external sources included, and clears while stopped, so each start is phase aligned
	always_comb begin
		r_next = r_reg;
		r_next.s1 = ext_count_pin;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		r_next.pre = (clock_source_sel == pct_pkg::CS_STOP) ? '0 : r_reg.pre + 1'b1;
		unique case (clock_source_sel)
			pct_pkg::CS_STOP: r_next.tick = 1'b0;
			pct_pkg::CS_DIV1: r_next.tick = 1'b1;
			pct_pkg::CS_DIV8: r_next.tick = tap_hit(r_reg.pre, pct_pkg::LOG2_DIV8);
			pct_pkg::CS_DIV64: r_next.tick = tap_hit(r_reg.pre, pct_pkg::LOG2_DIV64);
			pct_pkg::CS_DIV256: r_next.tick = tap_hit(r_reg.pre, pct_pkg::LOG2_DIV256);
			pct_pkg::CS_DIV1024: r_next.tick = tap_hit(r_reg.pre, pct_pkg::LOG2_DIV1024);
			pct_pkg::CS_EXT_FALL: r_next.tick = r_reg.s3 & ~r_reg.s2;
			pct_pkg::CS_EXT_RISE: r_next.tick = r_reg.s2 & ~r_reg.s3;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign timer_tick = r_reg.tick;
endmodule : pct_prescaler

// *** rtl/pct_capture.sv ***
// capture pin synchroniser, noise filter and edge select
`timescale 1ns/1ps
module pct_capture (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// asynchronous capture pin
	input wire logic capture_pin,
	// control from the core, event back to it
	pct_cap_if.unit cap
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic [pct_pkg::FILTER_SAMPLES-1:0] hist;
		logic filt;
		logic evt;
	} pct_cap_state_t;

	pct_cap_state_t r_reg, r_next;
	logic new_level;

	////////////////////////////////////////////////////////////////
	// with the filter on, the filtered level moves only when all four recent samples agree; with it off it follows the synchroniser
	always_comb begin
		r_next = r_reg;
		new_level = r_reg.filt;
		r_next.s1 = capture_pin;
		r_next.s2 = r_reg.s1;
		r_next.hist = {r_reg.hist[pct_pkg::FILTER_SAMPLES-2:0], r_reg.s2};
		if (!cap.filter_en) begin
			new_level = r_reg.s2;
		end else if (&r_next.hist || ~|r_next.hist) begin
			new_level = r_next.hist[0];
		end
		r_next.filt = new_level;
		// falling edge when select is zero, rising when one
		r_next.evt = cap.enable && (new_level != r_reg.filt) && (new_level == cap.edge_sel);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign cap.event_pulse = r_reg.evt;
endmodule : pct_capture

// *** rtl/pct_timer.sv ***
// 16-bit timer with fast and phase correct pwm, compare outputs and input capture
//
// Function
// - prescaler gives clock divided 1,8,64,256,1024
// - fast pwm compare at bottom gives spike
// - fast pwm compare at top gives constant
// - mode 15 toggle mode flips output A
// - fast pwm toggle keeps compare double buffered
// - phase correct counts up then down
// - phase correct clears up, sets down
// - phase correct top fixed or from registers
// - counter holds top one timer clock
// - compare match sets channel flag
// - noise filter needs four equal samples
// - edge select: zero falling, one rising
// - capture copies counter and sets flag
// - capture off when capture register is top
// - clock select zero stops, 001 to 101 prescaler
// - codes 110/111 count external pin edges
`timescale 1ns/1ps
module pct_timer (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// pins
	input wire logic capture_pin,
	input wire logic ext_count_pin,
	output logic compare_out_a,
	output logic compare_out_b,
	// interrupt
	output logic irq
);
	typedef struct packed {
		logic [7:0] ctrl_a;
		logic [7:0] counter_control_b;
		logic [15:0] counter_value;
		logic [15:0] cmp_a;
		logic [15:0] cmp_a_buf;
		logic [15:0] cmp_b;
		logic [15:0] cmp_b_buf;
		logic [15:0] capture_value;
		logic count_up;
		logic wave_a;
		logic wave_b;
		logic pin_a;
		logic pin_b;
		logic block;
		logic [pct_pkg::STAT_W-1:0] status;
		logic [pct_pkg::STAT_W-1:0] mask;
		logic [15:0] rdata;
	} pct_core_state_t;

	pct_core_state_t r_reg, r_next;
	pct_cap_if cap_bus ();
	logic timer_tick;

	////////////////////////////////////////////////////////////////
	// mode decoding

	function automatic logic is_dual(input logic [3:0] m);
		return m inside {pct_pkg::WM_PC8, pct_pkg::WM_PC9, pct_pkg::WM_PC10, pct_pkg::WM_PFC_ICR,
			pct_pkg::WM_PFC_A, pct_pkg::WM_PC_ICR, pct_pkg::WM_PC_A};
	endfunction : is_dual

	function automatic logic is_fast(input logic [3:0] m);
		return m inside {pct_pkg::WM_FAST8, pct_pkg::WM_FAST9, pct_pkg::WM_FAST10, pct_pkg::WM_FAST_ICR,
			pct_pkg::WM_FAST_A};
	endfunction : is_fast

	function automatic logic capture_is_top(input logic [3:0] m);
		return m inside {pct_pkg::WM_PFC_ICR, pct_pkg::WM_PC_ICR, pct_pkg::WM_CTC_ICR, pct_pkg::WM_FAST_ICR};
	endfunction : capture_is_top

	function automatic logic cmp_a_is_top(input logic [3:0] m);
		return m inside {pct_pkg::WM_CTC_A, pct_pkg::WM_PFC_A, pct_pkg::WM_PC_A, pct_pkg::WM_FAST_A};
	endfunction : cmp_a_is_top

	// counter end value for a mode
	function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] a, input logic [15:0] icr);
		logic [15:0] t;
		t = pct_pkg::TOP_MAX;
		if (m == pct_pkg::WM_PC8 || m == pct_pkg::WM_FAST8) begin
			t = pct_pkg::TOP_8BIT;
		end else if (m == pct_pkg::WM_PC9 || m == pct_pkg::WM_FAST9) begin
			t = pct_pkg::TOP_9BIT;
		end else if (m == pct_pkg::WM_PC10 || m == pct_pkg::WM_FAST10) begin
			t = pct_pkg::TOP_10BIT;
		end else if (capture_is_top(m)) begin
			t = icr;
		end else if (cmp_a_is_top(m)) begin
			t = a;
		end
		return t;
	endfunction : top_of

	// waveform state after one timer clock; wrap is the fast pwm return to bottom
	function automatic logic wave_step(input logic cur, input logic [1:0] com, input logic match,
		input logic dual, input logic fast, input logic up, input logic wrap, input logic toggle_ok);
		logic w;
		w = cur;
		if (match) begin
			unique case (com)
				pct_pkg::COM_OFF: w = cur;
				pct_pkg::COM_TOGGLE: w = toggle_ok ? ~cur : cur;
				pct_pkg::COM_CLEAR: w = dual ? ~up : 1'b0;
				pct_pkg::COM_SET: w = dual ? up : 1'b1;
			endcase
		end
		// the bottom action follows the match, so a compare at top leaves a constant level
		if (fast && wrap) begin
			if (com == pct_pkg::COM_CLEAR) begin
				w = 1'b1;
			end else if (com == pct_pkg::COM_SET) begin
				w = 1'b0;
			end
		end
		return w;
	endfunction : wave_step

	// pin follows the waveform only where the mode connects it
	function automatic logic pin_of(input logic w, input logic [1:0] com, input logic pwm, input logic toggle_ok);
		logic p;
		p = w;
		if (com == pct_pkg::COM_OFF || (pwm && com == pct_pkg::COM_TOGGLE && !toggle_ok)) begin
			p = 1'b0;
		end
		return p;
	endfunction : pin_of

	////////////////////////////////////////////////////////////////
	// submodules

	pct_prescaler u_prescaler (
		.clk(clk),
		.srst(srst),
		.clock_source_sel(r_reg.counter_control_b[pct_pkg::CB_CS_LSB +: 3]),
		.ext_count_pin(ext_count_pin),
		.timer_tick(timer_tick)
	);

	pct_capture u_capture (
		.clk(clk),
		.srst(srst),
		.capture_pin(capture_pin),
		.cap(cap_bus.unit)
	);

	function automatic logic [3:0] wave_mode_of(input logic [7:0] ca, input logic [7:0] cb);
		return {cb[pct_pkg::CB_WGM_LSB +: 2], ca[pct_pkg::CA_WGM_LSB +: 2]};
	endfunction : wave_mode_of

	// capture control taken straight from the register copy
	assign cap_bus.filter_en = r_reg.counter_control_b[pct_pkg::CB_FILTER_BIT];
	assign cap_bus.edge_sel = r_reg.counter_control_b[pct_pkg::CB_EDGE_BIT];
	assign cap_bus.enable = !capture_is_top(wave_mode_of(r_reg.ctrl_a, r_reg.counter_control_b));

	////////////////////////////////////////////////////////////////
	// counter, compare, capture and register next state

	logic [3:0] waveform_mode;
	logic [1:0] compare_output_mode_a;
	logic [1:0] compare_output_mode_b;
	logic dual;
	logic fast;
	logic pwm;
	logic [15:0] top;
	logic at_top;
	logic wrap;
	logic match_a;
	logic match_b;
	logic tog_a;
	logic [pct_pkg::STAT_W-1:0] events;

	always_comb begin
		r_next = r_reg;
		waveform_mode = wave_mode_of(r_reg.ctrl_a, r_reg.counter_control_b);
		compare_output_mode_a = r_reg.ctrl_a[pct_pkg::CA_COMA_LSB +: 2];
		compare_output_mode_b = r_reg.ctrl_a[pct_pkg::CA_COMB_LSB +: 2];
		dual = is_dual(waveform_mode);
		fast = is_fast(waveform_mode);
		pwm = dual | fast;
		top = top_of(waveform_mode, r_reg.cmp_a, r_reg.capture_value);
		at_top = (r_reg.counter_value == top);
		events = '0;
		// toggle on A only in non-pwm modes or where compare A sets the top
		tog_a = !pwm || waveform_mode == pct_pkg::WM_FAST_A || waveform_mode == pct_pkg::WM_PC_A
			|| waveform_mode == pct_pkg::WM_PFC_A;

		// a write of the counter blocks matches on the following tick
		match_a = timer_tick && !r_reg.block && (r_reg.counter_value == r_reg.cmp_a);
		match_b = timer_tick && !r_reg.block && (r_reg.counter_value == r_reg.cmp_b);
		wrap = timer_tick && fast && at_top;
		if (timer_tick) begin
			r_next.block = 1'b0;
		end

		// counting
		if (timer_tick) begin
			if (dual) begin
				if (r_reg.count_up && at_top) begin
					// top was shown for this whole timer clock; turn round now
					r_next.count_up = 1'b0;
					r_next.counter_value = r_reg.counter_value - 16'h0001;
					r_next.cmp_a = r_reg.cmp_a_buf;
					r_next.cmp_b = r_reg.cmp_b_buf;
				end else if (!r_reg.count_up && r_reg.counter_value == 16'h0000) begin
					r_next.count_up = 1'b1;
					r_next.counter_value = 16'h0001;
					events[pct_pkg::ST_OVF] = 1'b1;
				end else if (r_reg.count_up) begin
					r_next.counter_value = r_reg.counter_value + 16'h0001;
				end else begin
					r_next.counter_value = r_reg.counter_value - 16'h0001;
				end
			end else if (at_top) begin
				// fast pwm and clear-on-match restart from bottom
				r_next.counter_value = 16'h0000;
				r_next.count_up = 1'b1;
				events[pct_pkg::ST_OVF] = fast || (top == pct_pkg::TOP_MAX);
				if (fast) begin
					// buffered compare values take effect at the period boundary
					r_next.cmp_a = r_reg.cmp_a_buf;
					r_next.cmp_b = r_reg.cmp_b_buf;
				end
			end else begin
				r_next.counter_value = r_reg.counter_value + 16'h0001;
				r_next.count_up = 1'b1;
			end
		end

		// compare outputs
		if (timer_tick) begin
			r_next.wave_a = wave_step(r_reg.wave_a, compare_output_mode_a, match_a, dual, fast,
				r_reg.count_up, wrap, tog_a);
			r_next.wave_b = wave_step(r_reg.wave_b, compare_output_mode_b, match_b, dual, fast,
				r_reg.count_up, wrap, !pwm);
		end
		r_next.pin_a = pin_of(r_next.wave_a, compare_output_mode_a, pwm, tog_a);
		r_next.pin_b = pin_of(r_next.wave_b, compare_output_mode_b, pwm, !pwm);
		events[pct_pkg::ST_CMP_A] = match_a;
		events[pct_pkg::ST_CMP_B] = match_b;

		// capture: enable already drops the event when capture value is the top
		if (cap_bus.event_pulse) begin
			r_next.capture_value = r_reg.counter_value;
			events[pct_pkg::ST_CAPT] = 1'b1;
		end

		// register writes; a cpu write beats the counter and capture updates
		if (reg_wr) begin
			unique case (reg_addr)
				pct_pkg::ADDR_CTRL_A: r_next.ctrl_a = reg_wdata[7:0] & pct_pkg::CTRL_A_WMASK;
				pct_pkg::ADDR_CTRL_B: r_next.counter_control_b = reg_wdata[7:0] & pct_pkg::CTRL_B_WMASK;
				pct_pkg::ADDR_COUNT: begin
					r_next.counter_value = reg_wdata;
					r_next.block = 1'b1;
				end
				pct_pkg::ADDR_CMP_A: begin
					r_next.cmp_a_buf = reg_wdata;
					if (!pwm) begin
						r_next.cmp_a = reg_wdata;
					end
				end
				pct_pkg::ADDR_CMP_B: begin
					r_next.cmp_b_buf = reg_wdata;
					if (!pwm) begin
						r_next.cmp_b = reg_wdata;
					end
				end
				pct_pkg::ADDR_CAPT: r_next.capture_value = reg_wdata;
				pct_pkg::ADDR_MASK: r_next.mask = reg_wdata[pct_pkg::STAT_W-1:0];
				default: r_next.block = r_next.block; // status and unmapped ignore writes
			endcase
		end

		// status: a read clears, an event in the same cycle still lands
		r_next.status = ((reg_rd && reg_addr == pct_pkg::ADDR_STATUS) ? '0 : r_reg.status) | events;

		// read data, one cycle after the strobe and only then
		r_next.rdata = 16'h0000;
		if (reg_rd) begin
			unique case (reg_addr)
				pct_pkg::ADDR_CTRL_A: r_next.rdata = {8'h00, r_reg.ctrl_a};
				pct_pkg::ADDR_CTRL_B: r_next.rdata = {8'h00, r_reg.counter_control_b};
				pct_pkg::ADDR_COUNT: r_next.rdata = r_reg.counter_value;
				pct_pkg::ADDR_CMP_A: r_next.rdata = r_reg.cmp_a_buf;
				pct_pkg::ADDR_CMP_B: r_next.rdata = r_reg.cmp_b_buf;
				pct_pkg::ADDR_CAPT: r_next.rdata = r_reg.capture_value;
				pct_pkg::ADDR_STATUS: r_next.rdata = {12'h000, r_reg.status};
				pct_pkg::ADDR_MASK: r_next.rdata = {12'h000, r_reg.mask};
				default: r_next.rdata = 16'h0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge clk) begin
		if (srst) begin
			r_reg <= '0;
			r_reg.ctrl_a <= pct_pkg::CTRL_RST;
			r_reg.counter_control_b <= pct_pkg::CTRL_RST;
			r_reg.counter_value <= pct_pkg::WORD_RST;
			r_reg.count_up <= 1'b1;
			r_reg.status <= pct_pkg::STAT_RST;
			r_reg.mask <= pct_pkg::STAT_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	// outputs
	assign reg_rdata = r_reg.rdata;
	assign compare_out_a = r_reg.pin_a;
	assign compare_out_b = r_reg.pin_b;
	// level interrupt while any unmasked flag is set
	assign irq = |(r_reg.status & r_reg.mask);
endmodule : pct_timer

// *** dv/pct_timer_assertions.sv ***
// concurrent checks on the timer's register port, compare pins and interrupt
`timescale 1ns/1ps
module pct_timer_assertions (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// pins and interrupt
	input wire logic capture_pin,
	input wire logic ext_count_pin,
	input wire logic compare_out_a,
	input wire logic compare_out_b,
	input wire logic irq
);
	logic [7:0] ctrl_a_sh;
	logic [3:0] mask_sh;
	////////////////////////////////////////////////////////////////////////
	// shadows of control a and mask, updated at the edge that takes the write
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_a_sh <= 8'h00;
			mask_sh <= 4'h0;
		end else begin
			if (reg_wr && reg_addr == pct_pkg::ADDR_CTRL_A) ctrl_a_sh <= reg_wdata[7:0];
			if (reg_wr && reg_addr == pct_pkg::ADDR_MASK) mask_sh <= reg_wdata[3:0];
		end
	end
	////////////////////////////////////////////////////////////////////////
	// one clock domain, so clocking and reset are given once
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data not zero outside its slot");
	a_ctrlb_reserved: assert property ($past(reg_rd) && $past(reg_addr) == pct_pkg::ADDR_CTRL_B
		|-> reg_rdata[5] == 1'b0 && reg_rdata[15:8] == 8'h00) else $error("reserved control bits read nonzero");
	a_ctrlb_readback: assert property ((reg_wr && reg_addr == pct_pkg::ADDR_CTRL_B)
		##1 (reg_rd && reg_addr == pct_pkg::ADDR_CTRL_B) |=> reg_rdata == ($past(reg_wdata, 2) & 16'h00DF))
		else $error("control b readback differs from write");
	a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) > 4'h7 |-> reg_rdata == 16'h0000)
		else $error("unmapped read returned data");
	a_irq_masked: assert property (irq |-> mask_sh != 4'h0)
		else $error("interrupt high with every source masked");
	a_irq_drop_cause: assert property ($fell(irq) |-> ($past(reg_rd) && $past(reg_addr) == pct_pkg::ADDR_STATUS)
		|| ($past(reg_wr) && $past(reg_addr) == pct_pkg::ADDR_MASK)) else $error("interrupt dropped on its own");
	a_outa_off: assert property ((ctrl_a_sh[7:6] == pct_pkg::COM_OFF) [*3] |-> !compare_out_a)
		else $error("output a driven while its mode is off");
	a_outb_off: assert property ((ctrl_a_sh[5:4] == pct_pkg::COM_OFF) [*3] |-> !compare_out_b)
		else $error("output b driven while its mode is off");
endmodule : pct_timer_assertions

// *** dv/pct_timer_tb.sv ***
// self-checking bench for the 16-bit waveform and capture timer
`timescale 1ns/1ps
module pct_timer_tb;
	logic clk, srst, reg_wr, reg_rd, capture_pin, ext_count_pin, compare_out_a, compare_out_b, irq;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, d, e;
	logic [15:0] samp[$];
	int miscompares, total_checks, hi, hb, edges, n;
	logic [10:0] div[5] = '{11'h001, 11'h008, 11'h040, 11'h100, 11'h400};
	logic [3:0] pc_mode[5] = '{4'h1, 4'h2, 4'h3, 4'hA, 4'hB};
	logic [15:0] pc_top[5] = '{16'h00FF, 16'h01FF, 16'h03FF, 16'h0005, 16'h0003};
	logic [15:0] fcmp[3] = '{16'h0000, 16'h00FF, 16'h0080};
	logic [7:0] cap_cb[7] = '{8'h41, 8'h41, 8'h01, 8'h01, 8'hC1, 8'hC1, 8'h59};
	logic [6:0] cap_lv = 7'h06, cap_pulse = 7'h10, cap_ex = 7'h25;
	pct_timer pct_timer_inst (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .capture_pin(capture_pin),
		.ext_count_pin(ext_count_pin), .compare_out_a(compare_out_a), .compare_out_b(compare_out_b), .irq(irq));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	// comparison, verdict and bus tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic rng(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] up);
		check({15'h0000, v >= lo && v <= up}, 16'h0001);
	endtask : rng
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	// a write directly followed by a read of the same place
	task automatic wrrd(input logic [3:0] a, input logic [15:0] v, output logic [15:0] r);
		wr(a, v);
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 r = reg_rdata;
	endtask : wrrd
	task automatic rd(input logic [3:0] a, output logic [15:0] r);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 r = reg_rdata;
	endtask : rd
	// back-to-back reads, one sample per cycle
	task automatic burst(input logic [3:0] a, input int cnt);
		samp.delete();
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		for (int i = 0; i < cnt; i++) begin
			@(posedge clk);
			if (i == cnt - 1) reg_rd <= 1'b0;
			#1 samp.push_back(reg_rdata);
		end
	endtask : burst
	task automatic measure(input int cnt);
		logic last;
		hi = 0;
		hb = 0;
		edges = 0;
		last = compare_out_a;
		repeat (cnt) begin
			@(posedge clk);
			#1;
			if (compare_out_a === 1'b1) hi++;
			if (compare_out_b === 1'b1) hb++;
			if (compare_out_a !== last) edges++;
			last = compare_out_a;
		end
	endtask : measure
	// compare written in normal mode, where it lands at once rather than in the buffer
	task automatic run_pwm(input logic [15:0] ca, input logic [15:0] cb, input logic [15:0] cmp, input int cnt);
		wr(pct_pkg::ADDR_CTRL_A, 16'h0000);
		wr(pct_pkg::ADDR_CTRL_B, 16'h0000);
		wr(pct_pkg::ADDR_CMP_A, cmp);
		wr(pct_pkg::ADDR_CMP_B, cmp);
		wr(pct_pkg::ADDR_COUNT, 16'h0000);
		wr(pct_pkg::ADDR_CTRL_A, ca);
		wr(pct_pkg::ADDR_CTRL_B, cb);
		measure(600);
		measure(cnt);
	endtask : run_pwm
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{srst, reg_wr, reg_rd, capture_pin, ext_count_pin} = 5'h10;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		rd(pct_pkg::ADDR_CTRL_B, d);
		check(d, 16'h0000);
		wrrd(pct_pkg::ADDR_CTRL_B, 16'hFFD8, d);
		check(d, 16'h00D8);
		wr(pct_pkg::ADDR_CTRL_B, 16'h0000);
		rd(4'h9, d);
		check(d, 16'h0000);
		wr(pct_pkg::ADDR_STATUS, 16'h000F);
		rd(pct_pkg::ADDR_STATUS, d);
		check(d, 16'h0000);
		for (int j = 0; j < 5; j++) begin
			wr(pct_pkg::ADDR_COUNT, 16'h0000);
			wr(pct_pkg::ADDR_CTRL_B, 16'(j + 1));
			repeat (4 * int'(div[j])) @(posedge clk);
			wr(pct_pkg::ADDR_CTRL_B, 16'h0000);
			rd(pct_pkg::ADDR_COUNT, d);
			rng(d, 16'h0003, 16'h0007);
			repeat (20) @(posedge clk);
			rd(pct_pkg::ADDR_COUNT, e);
			check(e, d);
		end
		for (int j = 0; j < 2; j++) begin
			wr(pct_pkg::ADDR_COUNT, 16'h0000);
			wr(pct_pkg::ADDR_CTRL_B, j ? 16'h0006 : 16'h0007);
			repeat (5) begin
				@(posedge clk);
				ext_count_pin <= 1'b1;
				repeat (10) @(posedge clk);
				ext_count_pin <= 1'b0;
				repeat (10) @(posedge clk);
			end
			wr(pct_pkg::ADDR_CTRL_B, 16'h0000);
			rd(pct_pkg::ADDR_COUNT, d);
			check(d, 16'h0005);
		end
		wr(pct_pkg::ADDR_CAPT, 16'h0005); // register tops stay at 3 or more
		for (int j = 0; j < 5; j++) begin
			run_pwm({14'h0000, pc_mode[j][1:0]}, {11'h000, pc_mode[j][3:2], 3'h1}, 16'h0003, 0);
			burst(pct_pkg::ADDR_COUNT, 2 * int'(pc_top[j]) + 4);
			e = 16'h0000;
			for (int i = 1; i < samp.size(); i++) begin
				d = samp[i] > samp[i-1] ? samp[i] - samp[i-1] : samp[i-1] - samp[i];
				check(d, 16'h0001);
				if (samp[i] > e) e = samp[i];
			end
			check(e, pc_top[j]);
		end
		rd(pct_pkg::ADDR_STATUS, d);
		check(d & 16'h0001, 16'h0001);
		for (int j = 0; j < 2; j++) begin
			run_pwm(j ? 16'h00F1 : 16'h00A1, 16'h0001, 16'h0040, 510);
			rng(16'(hi), j ? 16'h017C : 16'h007E, j ? 16'h0180 : 16'h0082);
			rng(16'(hb), j ? 16'h017C : 16'h007E, j ? 16'h0180 : 16'h0082);
		end
		for (int j = 0; j < 3; j++) begin
			run_pwm(16'h0081, 16'h0009, fcmp[j], 512);
			check(16'(edges), j == 1 ? 16'h0000 : 16'h0004);
			if (j == 0) check(16'(hi), 16'h0002);
		end
		for (int j = 0; j < 2; j++) begin
			run_pwm(16'h0043, 16'h0019, j ? 16'h0003 : 16'h0000, 80);
			check(16'(edges), j ? 16'h0014 : 16'h0050);
		end
		// clear-on-match toggle with compare a as top, written straight to the active value
		run_pwm(16'h0040, 16'h0009, 16'h0003, 80);
		check(16'(edges), 16'h0014);
		// capture cases: start level, then the opposite level held or as a short glitch
		wr(pct_pkg::ADDR_CTRL_A, 16'h0000);
		wr(pct_pkg::ADDR_MASK, 16'h0004);
		for (int j = 0; j < 7; j++) begin
			wr(pct_pkg::ADDR_CTRL_B, {8'h00, cap_cb[j]});
			capture_pin <= cap_lv[j];
			repeat (10) @(posedge clk);
			rd(pct_pkg::ADDR_STATUS, d);
			capture_pin <= ~cap_lv[j];
			if (cap_pulse[j]) begin
				repeat (2) @(posedge clk);
				capture_pin <= cap_lv[j];
			end
			for (n = 0; n < 20 && irq !== 1'b1; n++) begin
				@(posedge clk);
				#1;
			end
			check({15'h0000, irq}, {15'h0000, cap_ex[j]});
			if (cap_ex[j] && n == 20) summarize();
			rd(pct_pkg::ADDR_CAPT, d);
			rd(pct_pkg::ADDR_COUNT, e);
			if (cap_ex[j]) rng(e - d, 16'h0001, 16'h0028);
		end
		wr(pct_pkg::ADDR_MASK, 16'h0000);
		wr(pct_pkg::ADDR_CTRL_B, 16'h0041);
		capture_pin <= 1'b0;
		repeat (10) @(posedge clk);
		rd(pct_pkg::ADDR_STATUS, d);
		capture_pin <= 1'b1;
		repeat (12) @(posedge clk);
		#1;
		check({15'h0000, irq}, 16'h0000);
		rd(pct_pkg::ADDR_STATUS, d);
		check(d & 16'h0004, 16'h0004);
		rd(pct_pkg::ADDR_STATUS, d);
		check(d & 16'h0004, 16'h0000);
		summarize();
	end
endmodule : pct_timer_tb
bind pct_timer pct_timer_assertions pct_timer_assertions_inst (.clk(clk), .srst(srst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .capture_pin(capture_pin),
	.ext_count_pin(ext_count_pin), .compare_out_a(compare_out_a), .compare_out_b(compare_out_b), .irq(irq));
